// File: hdl/shift_clock_edges.sv
// Edge detector for the externally supplied shift clock
`timescale 1ns/100ps
module shift_clock_edges (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Shift clock
    input wire logic i_clk_pin,
    input wire logic i_polarity,
    input wire logic i_hold,
    // Edge strobes
    output logic o_launch,
    output logic o_sample
);
    logic prev;
    logic next_prev;
    logic next_launch;
    logic next_sample;
    logic rise;
    logic fall;

    always_comb begin
        next_prev = i_clk_pin;
        rise = i_clk_pin & ~prev;
        fall = ~i_clk_pin & prev;
        // Idle-low clock launches on rising, idle-high inverts the pair
        next_launch = ~i_hold & (i_polarity ? fall : rise); // RULE20
        next_sample = ~i_hold & (i_polarity ? rise : fall); // RULE20
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            prev <= 1'b0;
            o_launch <= 1'b0;
            o_sample <= 1'b0;
        end else begin
            prev <= next_prev;
            o_launch <= next_launch;
            o_sample <= next_sample;
        end
    end
endmodule : shift_clock_edges

// File: hdl/usart_sync_consts.svh
// Constants for the synchronous slave transceiver and its register port
`ifndef USART_SYNC_CONSTS_SVH
`define USART_SYNC_CONSTS_SVH
// Register indices on the plain port
`define ADDR_RCV_CTRL 3'h0
`define ADDR_XMT_CTRL 3'h1
`define ADDR_XMT_HOLD 3'h2
`define ADDR_RCV_DATA 3'h3
`define ADDR_DIV_LOW 3'h4
`define ADDR_DIV_HIGH 3'h5
`define ADDR_BAUD_CTRL 3'h6
`define ADDR_INT_CTRL 3'h7
// receive_status_control fields
`define RC_SERIAL_PORT_ENABLE 7
`define RC_RX9 6
`define RC_SINGLE_RECEIVE_ENABLE 5
`define RC_CONTINUOUS_RECEIVE_ENABLE 4
`define RC_ADDRESS_DETECT_ENABLE 3
`define RC_FERR 2
`define RC_OERR 1
`define RC_RECEIVED_NINTH_BIT 0
// transmit_status_control fields
`define TC_CLOCK_SOURCE_SELECT 7
`define TC_TX9 6
`define TC_TRANSMITTER_ON 5
`define TC_SYNC 4
`define TC_TRMT 1
`define TC_TRANSMIT_NINTH_BIT 0
// baud control field
`define BC_CLOCK_POLARITY_SELECT 4
// interrupt control fields
`define IC_GIE 7
`define IC_PERIPHERAL_INTERRUPT_ENABLE 6
`define IC_TRANSMIT_INTERRUPT_ENABLE 5
`define IC_TRANSMIT_INTERRUPT_FLAG 0
`define RESET_BYTE 8'h00
`define BIT_COUNT_NINE 4'h9
`define BIT_COUNT_EIGHT 4'h8
`define ONE_BIT 4'h1
`define COUNT_CLEAR 4'h0
`define STATUS_CLEAR 3'h0
`define SHIFT_CLEAR 9'h000
`endif

// File: hdl/usart_sync_pkg.sv
// Types shared by the synchronous slave transceiver files
package usart_sync_pkg;
    typedef enum logic [2:0] {
        XMT_IDLE = 3'b001,
        XMT_SHIFT = 3'b010,
        XMT_LOAD = 3'b100
    } xmt_state_t;

    typedef struct packed {
        logic serial_port_enable;
        logic sync_mode;
        logic clock_source_select;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic clock_polarity_select;
    } mode_t;

    typedef struct packed {
        logic [7:0] data;
        logic ninth;
    } word_t;
endpackage : usart_sync_pkg

// File: hdl/usart_sync_slave.sv
// Receive control and synchronous slave transceiver core
// Functional notes
// RULE1 - Port enable on, else held in reset
// RULE2 - Clocked-mode bit selects synchronous operation
// RULE3 - Cleared clock source makes a slave
// RULE4 - Slave transmits unless a receive enable set
// RULE5 - Single receive in master only, self-clears
// RULE6 - Continuous receive runs, overrides single receive
// RULE7 - Address detect keeps only ninth-bit-one characters
// RULE8 - Ninth received bit shown, no parity
// RULE9 - Slave transmit behaves like master transmit
// RULE10 - In sleep first word shifts at once
// RULE11 - Second word held, flag clear meanwhile
// RULE12 - After shifting, load second, then flag
// RULE13 - Enabled flag wakes the sleeping core
// RULE14 - Global enable also requests service routine
// RULE15 - Software sets mode before clearing receive enables
// RULE16 - Software sets ninth bit before data
// RULE17 - Transmit enable first, holding write starts
// RULE18 - Sixteen-bit divisor in low and high bytes
// RULE19 - Flag set when holding empty and enabled
// RULE20 - Shift LSB first on selected clock edge
`timescale 1ns/100ps
`include "usart_sync_consts.svh"
module usart_sync_slave #(
    parameter int DATA_BITS = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Core state
    input wire logic i_core_sleep,
    // Link pins
    input wire logic i_shift_clock_pin,
    input wire logic i_data_pin,
    output logic o_data_pin,
    output logic o_data_oe,
    // Core events
    output logic o_wake,
    output logic o_isr_request,
    output logic o_rcv_event
);
    if (DATA_BITS != 8) begin : g_width_check
        $error("usart_sync_slave: only eight data bits supported");
    end

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0] rcv_ctrl, next_rcv_ctrl;
    logic [7:0] xmt_ctrl, next_xmt_ctrl;
    logic [7:0] div_low, next_div_low;
    logic [7:0] div_high, next_div_high;
    logic [7:0] baud_ctrl, next_baud_ctrl;
    logic [7:0] int_ctrl, next_int_ctrl;
    logic [7:0] rcv_data, next_rcv_data;
    logic [7:0] rdata_q, next_rdata;
    usart_sync_pkg::word_t hold, next_hold;
    logic hold_full, next_hold_full;
    logic transmit_interrupt_flag, next_transmit_interrupt_flag;
    usart_sync_pkg::mode_t mode;
    logic [15:0] divisor;
    logic port_on;
    logic slave_sync;
    logic slave_xmt;
    logic slave_rcv;
    logic launch;
    logic sample;

    // ----------------------------------------
    // Transmit and receive shift state
    // ----------------------------------------
    usart_sync_pkg::xmt_state_t xstate, next_xstate;
    logic [8:0] transmit_shift_register, next_tsr;
    logic [3:0] xcount, next_xcount;
    logic [8:0] receive_shift_register, next_rsr;
    logic [3:0] rcount, next_rcount;
    logic data_out, next_data_out;
    logic data_oe, next_data_oe;
    logic rcv_pulse, next_rcv_pulse;
    logic wake, next_wake;
    logic isr, next_isr;
    logic [3:0] frame_len;
    logic rcv_done;
    logic accept;
    logic hold_take;

    always_comb begin
        mode.serial_port_enable = rcv_ctrl[`RC_SERIAL_PORT_ENABLE];
        mode.sync_mode = xmt_ctrl[`TC_SYNC];
        mode.clock_source_select = xmt_ctrl[`TC_CLOCK_SOURCE_SELECT];
        mode.single_receive_enable = rcv_ctrl[`RC_SINGLE_RECEIVE_ENABLE];
        mode.continuous_receive_enable = rcv_ctrl[`RC_CONTINUOUS_RECEIVE_ENABLE];
        mode.clock_polarity_select = baud_ctrl[`BC_CLOCK_POLARITY_SELECT];
        divisor = {div_high, div_low}; // RULE18
        port_on = mode.serial_port_enable; // RULE1
        slave_sync = port_on & mode.sync_mode & ~mode.clock_source_select; // RULE2 RULE3
        // Single receive is ignored as slave, but still selects receive direction
        slave_rcv = slave_sync & (mode.continuous_receive_enable | mode.single_receive_enable); // RULE4 RULE6
        slave_xmt = slave_sync & ~slave_rcv & xmt_ctrl[`TC_TRANSMITTER_ON]; // RULE4 RULE9
        frame_len = xmt_ctrl[`TC_TX9] ? `BIT_COUNT_NINE : `BIT_COUNT_EIGHT;
    end

    shift_clock_edges u_edges (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_pin(i_shift_clock_pin),
        .i_polarity(mode.clock_polarity_select),
        .i_hold(~slave_sync),
        .o_launch(launch),
        .o_sample(sample)
    );

    // ----------------------------------------
    // Shift engines
    // ----------------------------------------
    always_comb begin
        next_xstate = xstate;
        next_tsr = transmit_shift_register;
        next_xcount = xcount;
        next_rsr = receive_shift_register;
        next_rcount = rcount;
        next_data_out = data_out;
        next_data_oe = slave_xmt;
        hold_take = 1'b0;
        rcv_done = 1'b0;
        case (xstate)
            usart_sync_pkg::XMT_IDLE: begin
                // Queued word moves to the shifter at once, asleep or not
                if (slave_xmt && hold_full) begin // RULE10 RULE17
                    hold_take = 1'b1;
                    next_tsr = {hold.ninth, hold.data};
                    next_xcount = `COUNT_CLEAR;
                    next_xstate = usart_sync_pkg::XMT_SHIFT;
                end
            end
            usart_sync_pkg::XMT_SHIFT: begin
                if (!slave_xmt) begin
                    next_xstate = usart_sync_pkg::XMT_IDLE;
                end else if (launch) begin
                    if (xcount == frame_len) begin
                        next_xstate = usart_sync_pkg::XMT_LOAD;
                    end else begin
                        next_data_out = transmit_shift_register[0]; // RULE20
                        next_tsr = {1'b0, transmit_shift_register[8:1]};
                        next_xcount = xcount + `ONE_BIT;
                    end
                end
            end
            usart_sync_pkg::XMT_LOAD: begin
                // Held second word follows once the first is out
                if (slave_xmt && hold_full) begin // RULE11 RULE12
                    hold_take = 1'b1;
                    next_tsr = {hold.ninth, hold.data};
                    next_xcount = `COUNT_CLEAR;
                    next_xstate = usart_sync_pkg::XMT_SHIFT;
                end else begin
                    next_xstate = usart_sync_pkg::XMT_IDLE;
                end
            end
            default: begin
                next_xstate = usart_sync_pkg::XMT_IDLE;
            end
        endcase
        if (slave_rcv && sample) begin
            // Bits land by index, so a stale ninth bit is harmless in 8-bit frames
            next_rsr[rcount] = i_data_pin; // RULE20
            if (rcount + `ONE_BIT == (rcv_ctrl[`RC_RX9] ? `BIT_COUNT_NINE : `BIT_COUNT_EIGHT)) begin
                rcv_done = 1'b1;
                next_rcount = `COUNT_CLEAR;
            end else begin
                next_rcount = rcount + `ONE_BIT;
            end
        end else if (!slave_rcv) begin
            next_rcount = `COUNT_CLEAR;
        end
        // Address detect drops characters whose ninth bit is zero
        accept = rcv_done & ~(rcv_ctrl[`RC_RX9] & rcv_ctrl[`RC_ADDRESS_DETECT_ENABLE] & ~next_rsr[8]); // RULE7
    end

    // ----------------------------------------
    // Register port and flags
    // ----------------------------------------
    always_comb begin
        next_rcv_ctrl = rcv_ctrl;
        next_xmt_ctrl = xmt_ctrl;
        next_div_low = div_low;
        next_div_high = div_high;
        next_baud_ctrl = baud_ctrl;
        next_int_ctrl = int_ctrl;
        next_rcv_data = rcv_data;
        next_hold = hold;
        next_hold_full = hold_full & ~hold_take;
        next_rdata = `RESET_BYTE;
        if (i_wr) begin
            if (i_addr == `ADDR_RCV_CTRL) begin
                next_rcv_ctrl[7:3] = i_wdata[7:3];
            end else if (i_addr == `ADDR_XMT_CTRL) begin
                next_xmt_ctrl = {i_wdata[7:2], 1'b0, i_wdata[0]};
            end else if (i_addr == `ADDR_XMT_HOLD) begin
                // Ninth bit must already sit in the control register
                next_hold.data = i_wdata; // RULE16 RULE17
                next_hold.ninth = xmt_ctrl[`TC_TRANSMIT_NINTH_BIT];
                next_hold_full = 1'b1;
            end else if (i_addr == `ADDR_DIV_LOW) begin
                next_div_low = i_wdata; // RULE18
            end else if (i_addr == `ADDR_DIV_HIGH) begin
                next_div_high = i_wdata; // RULE18
            end else if (i_addr == `ADDR_BAUD_CTRL) begin
                next_baud_ctrl = i_wdata;
            end else if (i_addr == `ADDR_INT_CTRL) begin
                next_int_ctrl = i_wdata;
            end
        end
        // Single receive self-clears only for a master; slave leaves it
        if (port_on && mode.sync_mode && mode.clock_source_select && rcv_done && !mode.continuous_receive_enable) begin
            next_rcv_ctrl[`RC_SINGLE_RECEIVE_ENABLE] = 1'b0; // RULE5
        end
        if (accept) begin
            next_rcv_data = next_rsr[7:0];
            next_rcv_ctrl[`RC_RECEIVED_NINTH_BIT] = rcv_ctrl[`RC_RX9] & next_rsr[8]; // RULE8
        end
        next_xmt_ctrl[`TC_TRMT] = (next_xstate == usart_sync_pkg::XMT_IDLE);
        // Flag stays clear while the second word waits for the shifter
        next_transmit_interrupt_flag = slave_xmt & ~next_hold_full; // RULE11 RULE12 RULE19
        if (!port_on) begin
            next_rcv_ctrl[2:0] = `STATUS_CLEAR; // RULE1
            next_hold_full = 1'b0;
            next_transmit_interrupt_flag = 1'b0;
        end
        if (i_rd) begin
            if (i_addr == `ADDR_RCV_CTRL) begin
                next_rdata = rcv_ctrl;
            end else if (i_addr == `ADDR_XMT_CTRL) begin
                next_rdata = xmt_ctrl;
            end else if (i_addr == `ADDR_XMT_HOLD) begin
                next_rdata = hold.data;
            end else if (i_addr == `ADDR_RCV_DATA) begin
                next_rdata = rcv_data;
            end else if (i_addr == `ADDR_DIV_LOW) begin
                next_rdata = divisor[7:0];
            end else if (i_addr == `ADDR_DIV_HIGH) begin
                next_rdata = divisor[15:8];
            end else if (i_addr == `ADDR_BAUD_CTRL) begin
                next_rdata = baud_ctrl;
            end else begin
                next_rdata = {int_ctrl[7:1], transmit_interrupt_flag};
            end
        end
        next_rcv_pulse = accept;
        next_wake = i_core_sleep & transmit_interrupt_flag & int_ctrl[`IC_PERIPHERAL_INTERRUPT_ENABLE] & int_ctrl[`IC_TRANSMIT_INTERRUPT_ENABLE]; // RULE13
        next_isr = transmit_interrupt_flag & int_ctrl[`IC_PERIPHERAL_INTERRUPT_ENABLE] & int_ctrl[`IC_TRANSMIT_INTERRUPT_ENABLE] & int_ctrl[`IC_GIE]; // RULE14
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rcv_ctrl <= `RESET_BYTE;
            xmt_ctrl <= `RESET_BYTE;
            div_low <= `RESET_BYTE;
            div_high <= `RESET_BYTE;
            baud_ctrl <= `RESET_BYTE;
            int_ctrl <= `RESET_BYTE;
            rcv_data <= `RESET_BYTE;
            rdata_q <= `RESET_BYTE;
            hold <= '0;
            hold_full <= 1'b0;
            transmit_interrupt_flag <= 1'b0;
            rcv_pulse <= 1'b0;
            wake <= 1'b0;
            isr <= 1'b0;
        end else begin
            rcv_ctrl <= next_rcv_ctrl;
            xmt_ctrl <= next_xmt_ctrl;
            div_low <= next_div_low;
            div_high <= next_div_high;
            baud_ctrl <= next_baud_ctrl;
            int_ctrl <= next_int_ctrl;
            rcv_data <= next_rcv_data;
            rdata_q <= next_rdata;
            hold <= next_hold;
            hold_full <= next_hold_full;
            transmit_interrupt_flag <= next_transmit_interrupt_flag;
            rcv_pulse <= next_rcv_pulse;
            wake <= next_wake;
            isr <= next_isr;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || !port_on) begin
            xstate <= usart_sync_pkg::XMT_IDLE; // RULE1
            transmit_shift_register <= `SHIFT_CLEAR;
            xcount <= `COUNT_CLEAR;
            receive_shift_register <= `SHIFT_CLEAR;
            rcount <= `COUNT_CLEAR;
            data_out <= 1'b0;
            data_oe <= 1'b0;
        end else begin
            xstate <= next_xstate;
            transmit_shift_register <= next_tsr;
            xcount <= next_xcount;
            receive_shift_register <= next_rsr;
            rcount <= next_rcount;
            data_out <= next_data_out;
            data_oe <= next_data_oe;
        end
    end

    always_comb begin
        o_rdata = rdata_q;
        o_data_pin = data_out;
        o_data_oe = data_oe;
        o_wake = wake;
        o_isr_request = isr;
        o_rcv_event = rcv_pulse;
    end
endmodule : usart_sync_slave

// File: testbench/sync_master_model.sv
// Behavioural synchronous master that drives the shift clock
`timescale 1ns/100ps
module sync_master_model #(
    parameter int HALF = 8
) (
    // Clock
    input wire logic i_ref_clk,
    // Link
    input wire logic i_pol,
    input wire logic i_sdi,
    output logic o_sck,
    output logic o_sdo
);
    initial begin
        o_sck = 1'b0;
        o_sdo = 1'b1;
    end
    // ------------------------------
    // One frame, LSB first
    // ------------------------------
    task automatic frame(input int n, input logic [8:0] d, input logic tail, output logic [8:0] q);
        q = 9'h000;
        @(posedge i_ref_clk);
        o_sck <= i_pol;
        repeat (HALF) @(posedge i_ref_clk);
        for (int i = 0; i < n; i++) begin
            o_sck <= ~i_pol;
            o_sdo <= d[i];
            repeat (HALF) @(posedge i_ref_clk);
            q[i] = i_sdi;
            o_sck <= i_pol;
            repeat (HALF) @(posedge i_ref_clk);
        end
        // Released line shows the inverse, never a stale bit
        o_sdo <= ~o_sdo;
        // Extra launch edge closes a transmit word
        if (tail) begin
            o_sck <= ~i_pol;
            repeat (HALF) @(posedge i_ref_clk);
            o_sck <= i_pol;
            repeat (HALF) @(posedge i_ref_clk);
        end
    endtask : frame
endmodule : sync_master_model

// File: testbench/tb_top.sv
// Self-checking bench for the synchronous slave transceiver
`timescale 1ns/100ps
`include "usart_sync_consts.svh"
module tb_top;
    logic i_ref_clk, i_rst_n, i_wr, i_rd, i_core_sleep, i_shift_clock_pin, i_data_pin, pol;
    logic [2:0] i_addr;
    logic [7:0] i_wdata, o_rdata;
    logic o_data_pin, o_data_oe, o_wake, o_isr_request, o_rcv_event;
    int n_fail = 0;
    int n_tests = 0;
    int ev_cnt = 0;

    usart_sync_slave #(.DATA_BITS(8)) dut (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_core_sleep(i_core_sleep),
        .i_shift_clock_pin(i_shift_clock_pin),
        .i_data_pin(i_data_pin),
        .o_data_pin(o_data_pin),
        .o_data_oe(o_data_oe),
        .o_wake(o_wake),
        .o_isr_request(o_isr_request),
        .o_rcv_event(o_rcv_event)
    );
    sync_master_model m (.i_ref_clk(i_ref_clk), .i_pol(pol), .i_sdi(o_data_pin), .o_sck(i_shift_clock_pin),
        .o_sdo(i_data_pin));

    always @(posedge i_ref_clk) if (o_rcv_event === 1'b1) ev_cnt <= ev_cnt + 1;

    // ------------------------------
    // Bus and compare helpers
    // ------------------------------
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    task chk(input string s, input logic [8:0] e, input logic [8:0] g);
        n_tests++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
            n_fail++;
        end
    endtask : chk
    task chkrd(input string s, input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(s, 9'(e), 9'(d));
    endtask : chkrd
    task settle;
        repeat (3) @(posedge i_ref_clk);
        #1;
    endtask : settle
    task test_done;
        if (n_fail == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // ------------------------------
    // Scenarios
    // ------------------------------
    task t_reset;
        chkrd("rcv_ctrl", `ADDR_RCV_CTRL, 8'h00);
        chk("drive_en", 9'h000, 9'(o_data_oe));
        chkrd("int_ctrl", `ADDR_INT_CTRL, 8'h00);
    endtask : t_reset
    task t_divisor;
        wr(`ADDR_DIV_LOW, 8'hA5);
        wr(`ADDR_DIV_HIGH, 8'h3C);
        chkrd("div_low", `ADDR_DIV_LOW, 8'hA5);
        chkrd("div_high", `ADDR_DIV_HIGH, 8'h3C);
    endtask : t_divisor
    task t_tx(input logic p, input logic [7:0] d);
        logic [8:0] q;
        wr(`ADDR_BAUD_CTRL, p ? 8'h10 : 8'h00);
        pol <= p;
        m.frame(0, 9'h000, 1'b0, q);
        wr(`ADDR_XMT_CTRL, 8'h10);
        wr(`ADDR_RCV_CTRL, 8'h80);
        wr(`ADDR_XMT_CTRL, 8'h30);
        settle;
        chk("drive_en", 9'h001, 9'(o_data_oe));
        wr(`ADDR_XMT_HOLD, d);
        m.frame(8, 9'h000, 1'b1, q);
        chk("tx_word", 9'(d), q);
    endtask : t_tx
    task t_tx9;
        logic [8:0] q;
        wr(`ADDR_XMT_CTRL, 8'h50);
        wr(`ADDR_XMT_CTRL, 8'h70);
        wr(`ADDR_XMT_CTRL, 8'h71);
        wr(`ADDR_XMT_HOLD, 8'hC3);
        m.frame(9, 9'h000, 1'b1, q);
        chk("tx_nine", 9'h1C3, q);
    endtask : t_tx9
    task t_sleep;
        logic [8:0] q;
        logic [7:0] v;
        wr(`ADDR_XMT_CTRL, 8'h30);
        wr(`ADDR_INT_CTRL, 8'hE0);
        wr(`ADDR_XMT_HOLD, 8'h3C);
        wr(`ADDR_XMT_HOLD, 8'hA6);
        @(posedge i_ref_clk);
        i_core_sleep <= 1'b1;
        fork
            m.frame(8, 9'h000, 1'b1, q);
            begin
                repeat (60) @(posedge i_ref_clk);
                rd(`ADDR_INT_CTRL, v);
                chk("flag", 9'h000, 9'(v[0]));
                chk("wake", 9'h000, 9'(o_wake));
            end
        join
        chk("first_word", 9'h03C, q);
        settle;
        chk("wake", 9'h001, 9'(o_wake));
        chk("isr", 9'h001, 9'(o_isr_request));
        wr(`ADDR_INT_CTRL, 8'h60);
        settle;
        chk("isr", 9'h000, 9'(o_isr_request));
        chk("wake", 9'h001, 9'(o_wake));
        @(posedge i_ref_clk);
        i_core_sleep <= 1'b0;
        m.frame(8, 9'h000, 1'b1, q);
        chk("second_word", 9'h0A6, q);
        rd(`ADDR_INT_CTRL, v);
        chk("flag", 9'h001, 9'(v[0]));
    endtask : t_sleep
    task rx_one(input int n, input logic [8:0] d, input int de, input logic [7:0] e);
        int c0;
        logic [8:0] q;
        c0 = ev_cnt;
        m.frame(n, d, 1'b0, q);
        repeat (4) @(posedge i_ref_clk);
        chk("rx_events", 9'(de), 9'(ev_cnt - c0));
        chkrd("rx_data", `ADDR_RCV_DATA, e);
    endtask : rx_one
    task t_rx;
        logic [7:0] v;
        wr(`ADDR_RCV_CTRL, 8'h90);
        settle;
        chk("drive_en", 9'h000, 9'(o_data_oe));
        rx_one(8, 9'h096, 1, 8'h96);
        rx_one(8, 9'h05B, 1, 8'h5B);
        wr(`ADDR_RCV_CTRL, 8'hD8);
        rx_one(9, 9'h011, 0, 8'h5B);
        rx_one(9, 9'h122, 1, 8'h22);
        chkrd("rcv_ctrl", `ADDR_RCV_CTRL, 8'hD9);
        wr(`ADDR_RCV_CTRL, 8'hA0);
        rx_one(8, 9'h081, 1, 8'h81);
        rd(`ADDR_RCV_CTRL, v);
        chk("single_kept", 9'h001, 9'(v[5]));
        wr(`ADDR_RCV_CTRL, 8'h00);
        settle;
        chk("drive_en", 9'h000, 9'(o_data_oe));
        wr(`ADDR_RCV_CTRL, 8'h80);
        settle;
        chk("drive_en", 9'h001, 9'(o_data_oe));
    endtask : t_rx

    // ------------------------------
    // Clock, sequence and watchdog
    // ------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 3'h0;
        i_wdata = 8'h00;
        i_core_sleep = 1'b0;
        pol = 1'b0;
        repeat (12) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_reset;
        t_divisor;
        t_tx(1'b0, 8'h5A);
        t_tx(1'b1, 8'hC6);
        t_tx9;
        t_sleep;
        t_rx;
        test_done;
    end
    // About ten frames of some 140 to 170 cycles each; ample margin
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        n_fail++;
        test_done;
    end
endmodule : tb_top

bind usart_sync_slave usart_sync_checker #(.DATA_BITS(DATA_BITS)) chk_i (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_core_sleep(i_core_sleep),
    .i_shift_clock_pin(i_shift_clock_pin),
    .i_data_pin(i_data_pin),
    .o_data_pin(o_data_pin),
    .o_data_oe(o_data_oe),
    .o_wake(o_wake),
    .o_isr_request(o_isr_request),
    .o_rcv_event(o_rcv_event)
);

// File: testbench/usart_sync_checker.sv
// Port-level assertions for the synchronous slave transceiver
`timescale 1ns/100ps
`include "usart_sync_consts.svh"
module usart_sync_checker #(
    parameter int DATA_BITS = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Core, link and events
    input wire logic i_core_sleep,
    input wire logic i_shift_clock_pin,
    input wire logic i_data_pin,
    input wire logic o_data_pin,
    input wire logic o_data_oe,
    input wire logic o_wake,
    input wire logic o_isr_request,
    input wire logic o_rcv_event
);
    // ------------------------------
    // Register mirror
    // ------------------------------
    logic [7:0] regs [0:7];
    logic [7:0] next_regs [0:7];
    logic slave;
    logic tx_ok;
    logic rx_on;
    always_comb begin
        next_regs = regs;
        if (i_wr) begin
            next_regs[i_addr] = i_wdata;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            regs <= '{default: 8'h00};
        end else begin
            regs <= next_regs;
        end
    end
    assign slave = regs[0][`RC_SERIAL_PORT_ENABLE] & regs[1][`TC_SYNC] & ~regs[1][`TC_CLOCK_SOURCE_SELECT];
    assign tx_ok = slave & ~regs[0][`RC_SINGLE_RECEIVE_ENABLE] & ~regs[0][`RC_CONTINUOUS_RECEIVE_ENABLE];
    assign rx_on = slave & (regs[0][`RC_SINGLE_RECEIVE_ENABLE] | regs[0][`RC_CONTINUOUS_RECEIVE_ENABLE]);

    // ------------------------------
    // Assertions
    // ------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("Read data not idle");
    a_div_low: assert property (i_rd && i_addr == `ADDR_DIV_LOW |=> o_rdata == $past(regs[4]))
        else $error("Divisor low byte readback wrong");
    a_div_high: assert property (i_rd && i_addr == `ADDR_DIV_HIGH |=> o_rdata == $past(regs[5]))
        else $error("Divisor high byte readback wrong");
    a_ctrl_read: assert property (i_rd && i_addr == `ADDR_RCV_CTRL |=> o_rdata[7:3] == $past(regs[0][7:3]))
        else $error("Receive control readback wrong");
    a_drive_tx_only: assert property (o_data_oe |-> $past(tx_ok))
        else $error("Data line driven outside slave transmit");
    a_event_rx_mode: assert property (o_rcv_event |-> $past(rx_on))
        else $error("Receive event outside receive mode");
    a_event_pulse: assert property (o_rcv_event |=> !o_rcv_event)
        else $error("Receive event longer than one cycle");
    a_wake_cause: assert property (o_wake |-> $past(i_core_sleep) && $past(regs[7][6] & regs[7][5]))
        else $error("Wake without sleep or enables");
    a_isr_cause: assert property (o_isr_request |-> $past(regs[7][7] & regs[7][6] & regs[7][5]))
        else $error("Service request without enables");
    cover property (o_rcv_event);
    cover property (o_wake);
    cover property (o_isr_request);
    cover property ($fell(o_data_oe));
endmodule : usart_sync_checker
